// ---- rtl/pll_qual_pkg.sv ----
// Shared constants and types for the PLL start-up lock qualifier
`default_nettype none
package pll_qual_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DIV_W = 6;
    localparam int CNT_W = 17;
    localparam int INT_W = 3;

    // Register offsets (byte addresses, one word each)
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SELECT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h10;

    // Control and select register fields
    localparam int CTRL_DISABLE_BIT = 0;
    localparam int CTRL_DIV_LSB = 8;
    localparam int CTRL_QUAL_BIT = 16;
    localparam int SELECT_PLL_BIT = 0;

    // Interrupt status and mask bits
    localparam int INT_LOCK_BIT = 0;
    localparam int INT_SLIP_BIT = 1;
    localparam int INT_REFUSED_BIT = 2;

    // Reset values
    localparam logic DISABLE_RESET = 1'b1;
    localparam logic [DIV_W-1:0] DIV_RESET = 6'h01;
    localparam logic [INT_W-1:0] MASK_RESET = 3'h0;

    // Lock time in oscillator input cycles: base plus unit times divider
    localparam int LOCK_BASE_CYCLES = 512;
    localparam int LOCK_UNIT_CYCLES = 1024;

    typedef struct packed {
        logic firstStart;
        logic slip;
        logic valid;
    } status_type;

    typedef enum logic [1:0] {IDLE, COUNTING, LOCKED} lock_state_type;
endpackage
`default_nettype wire

// ---- rtl/pll_startup_lock_qualifier.sv ----
// PLL start-up lock sequencing, lock qualification and clock source guarding
//
// What this block does
// - Lock after enable, then set valid status
// - Report valid and slip for three failure signatures
// - Failure possible only on first start after power-on
// - Proper lock stays; re-enable works cleanly
// - PLL selection only after full qualification
// - Lock time 512 plus 1024 times divider
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`default_nettype none
module pll_startup_lock_qualifier #(
    parameter int LOCK_BASE = pll_qual_pkg::LOCK_BASE_CYCLES,
    parameter int LOCK_UNIT = pll_qual_pkg::LOCK_UNIT_CYCLES
) (
    // Clock (oscillator input) and power-on reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire logic [pll_qual_pkg::ADDR_W-1:0] addr,
    input wire logic [pll_qual_pkg::DATA_W-1:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [pll_qual_pkg::DATA_W-1:0] rdData,
    // Analog PLL side
    input wire logic pllLockIn,
    input wire logic pllSlipIn,
    output logic clockSourceDisable,
    output logic [pll_qual_pkg::DIV_W-1:0] pllInputDivider,
    output logic mainClockSourceSelect,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    logic lockMeta;
    logic lockSync;
    logic slipMeta;
    logic slipSync;
    logic slipSyncDly;
    pll_qual_pkg::lock_state_type state;
    logic [pll_qual_pkg::CNT_W-1:0] lockCount;
    logic [pll_qual_pkg::CNT_W-1:0] lockTarget;
    pll_qual_pkg::status_type status;
    logic freqQualified;
    logic [pll_qual_pkg::INT_W-1:0] intStatus;
    logic [pll_qual_pkg::INT_W-1:0] intMask;
    logic [pll_qual_pkg::INT_W-1:0] events;
    logic [pll_qual_pkg::INT_W-1:0] next_intStatus;
    logic wrCtrl;
    logic wrSelect;
    logic lockDone;
    logic selectOk;
    logic selectRefused;

    assign wrCtrl = wrEn && (addr == pll_qual_pkg::OFF_CTRL);
    assign wrSelect = wrEn && (addr == pll_qual_pkg::OFF_SELECT);
    assign lockDone = (state == pll_qual_pkg::COUNTING) && !clockSourceDisable
                      && (lockCount == lockTarget - 17'h00001);
    assign selectOk = status.valid && !status.slip && freqQualified && !clockSourceDisable;
    assign selectRefused = wrSelect && wrData[pll_qual_pkg::SELECT_PLL_BIT] && !selectOk;

    ////////////////////////////////////////////////////////////////////////
    // PLL lock and slip indications are analog and asynchronous
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lockMeta <= 1'b0;
            lockSync <= 1'b0;
            slipMeta <= 1'b0;
            slipSync <= 1'b0;
            slipSyncDly <= 1'b0;
        end else begin
            lockMeta <= pllLockIn;
            lockSync <= lockMeta;
            slipMeta <= pllSlipIn;
            slipSync <= slipMeta;
            slipSyncDly <= slipSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clockSourceDisable <= pll_qual_pkg::DISABLE_RESET;
            pllInputDivider <= pll_qual_pkg::DIV_RESET;
        end else if (wrCtrl) begin
            clockSourceDisable <= wrData[pll_qual_pkg::CTRL_DISABLE_BIT];
            pllInputDivider <= wrData[pll_qual_pkg::CTRL_DIV_LSB +: pll_qual_pkg::DIV_W];
        end
    end

    // A frequency check belongs to one lock attempt; a new attempt needs a new check
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            freqQualified <= 1'b0;
        end else if (state == pll_qual_pkg::IDLE) begin
            freqQualified <= 1'b0;
        end else if (wrCtrl) begin
            freqQualified <= wrData[pll_qual_pkg::CTRL_QUAL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock sequencer; divider is latched at enable so a late write cannot stretch it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= pll_qual_pkg::IDLE;
            lockCount <= '0;
            lockTarget <= '0;
        end else begin
            case (state)
                pll_qual_pkg::IDLE: begin
                    lockCount <= '0;
                    if (!clockSourceDisable) begin
                        state <= pll_qual_pkg::COUNTING;
                        lockTarget <= 17'(LOCK_BASE + LOCK_UNIT * int'(pllInputDivider));
                    end
                end
                pll_qual_pkg::COUNTING: begin
                    if (clockSourceDisable) begin
                        state <= pll_qual_pkg::IDLE;
                    end else if (lockDone) begin
                        state <= pll_qual_pkg::LOCKED;
                    end else begin
                        lockCount <= lockCount + 17'h00001;
                    end
                end
                pll_qual_pkg::LOCKED: begin
                    if (clockSourceDisable) begin
                        state <= pll_qual_pkg::IDLE;
                    end
                end
                default: begin
                    state <= pll_qual_pkg::IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Valid shows the PLL lock at expiry; it is held until disable, so a lock-then-slip shows both
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status.valid <= 1'b0;
        end else if (state == pll_qual_pkg::IDLE || clockSourceDisable) begin
            status.valid <= 1'b0;
        end else if (lockDone) begin
            status.valid <= lockSync;
        end
    end

    // Slip is sticky for the attempt; a loss of lock after valid counts as a slip
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status.slip <= 1'b0;
        end else if (state == pll_qual_pkg::IDLE) begin
            status.slip <= 1'b0;
        end else if (slipSync || (status.valid && !lockSync)) begin
            status.slip <= 1'b1;
        end
    end

    // Only a qualified lock ends the power-on window; a later re-enable is clean
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status.firstStart <= 1'b1;
        end else if (selectOk) begin
            status.firstStart <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main clock select: unqualified requests are discarded, the clock stays on the oscillator
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mainClockSourceSelect <= 1'b0;
        end else if (!selectOk && !(wrSelect && !wrData[pll_qual_pkg::SELECT_PLL_BIT]) && clockSourceDisable) begin
            mainClockSourceSelect <= 1'b0;
        end else if (wrSelect) begin
            mainClockSourceSelect <= wrData[pll_qual_pkg::SELECT_PLL_BIT] && selectOk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: a read clears, an event in the same cycle survives
    assign events = {selectRefused, slipSync && !slipSyncDly && (state != pll_qual_pkg::IDLE), lockDone};
    assign next_intStatus = ((rdEn && addr == pll_qual_pkg::OFF_INT_STATUS) ? '0 : intStatus) | events;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            intStatus <= '0;
            intMask <= pll_qual_pkg::MASK_RESET;
            irq <= 1'b0;
        end else begin
            intStatus <= next_intStatus;
            irq <= |(next_intStatus & (wrEn && addr == pll_qual_pkg::OFF_INT_MASK
                                       ? wrData[pll_qual_pkg::INT_W-1:0] : intMask));
            if (wrEn && addr == pll_qual_pkg::OFF_INT_MASK) begin
                intMask <= wrData[pll_qual_pkg::INT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdData <= '0;
        end else if (rdEn) begin
            case (addr)
                pll_qual_pkg::OFF_CTRL: begin
                    rdData <= {15'h0000, freqQualified, 2'h0, pllInputDivider, 7'h00, clockSourceDisable};
                end
                pll_qual_pkg::OFF_STATUS: rdData <= {29'h00000000, status};
                pll_qual_pkg::OFF_SELECT: rdData <= {31'h00000000, mainClockSourceSelect};
                pll_qual_pkg::OFF_INT_STATUS: rdData <= {29'h00000000, intStatus};
                pll_qual_pkg::OFF_INT_MASK: rdData <= {29'h00000000, intMask};
                default: rdData <= '0;
            endcase
        end else begin
            rdData <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_lock_expiry_time: assert property (
        (state == pll_qual_pkg::COUNTING && !clockSourceDisable && lockCount == lockTarget - 17'h00001)
        |=> state == pll_qual_pkg::LOCKED) else $error("lock count end did not reach locked state");
    a_lock_target_set: assert property (
        $rose(state == pll_qual_pkg::COUNTING)
        |-> lockTarget == 17'(LOCK_BASE + LOCK_UNIT * int'($past(pllInputDivider))))
        else $error("lock target differs from base plus unit times divider");
    a_valid_after_lock: assert property (
        $rose(status.valid) |-> $past(lockDone) && $past(lockSync)) else $error("valid rose without lock at expiry");
    a_valid_held_enabled: assert property (
        status.valid && !clockSourceDisable |=> status.valid) else $error("valid dropped while enabled");
    a_slip_signature: assert property (
        state != pll_qual_pkg::IDLE && slipSync |=> status.slip) else $error("slip not recorded");
    a_disable_clears: assert property (
        clockSourceDisable |=> !status.valid ##1 !status.slip && !mainClockSourceSelect)
        else $error("disable did not clear valid, slip and select");
    a_first_start_once: assert property (
        !status.firstStart |=> !status.firstStart) else $error("first-start window reopened");
    a_select_qualified: assert property (
        $rose(mainClockSourceSelect) |-> $past(status.valid && !status.slip && freqQualified))
        else $error("PLL selected without qualification");
    a_irq_follows: assert property (
        intStatus == '0 |-> !irq) else $error("interrupt without pending status");

    c_good_lock: cover property ($rose(status.valid) ##[1:20] mainClockSourceSelect);
    c_valid_with_slip: cover property (status.valid && status.slip);
    c_slip_no_valid: cover property (lockDone && !lockSync && slipSync);
    c_refused: cover property (selectRefused);

endmodule
`default_nettype wire

// ---- sim/pll_analog_model.sv ----
// Behavioural PLL model facing the lock qualifier
`default_nettype none
module pll_analog_model (
    // Clock and control from the block
    input wire logic sys_clk,
    input wire logic clockSourceDisable,
    // Fault injection from the bench
    input wire logic injectSlip,
    // Indicators to the block
    output logic pllLockIn,
    output logic pllSlipIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] runCnt = 5'h00;
    logic everLocked = 1'b0;
    initial begin
        pllLockIn = 1'b0;
        pllSlipIn = 1'b0;
    end
    always @(posedge sys_clk) begin
        if (clockSourceDisable) begin
            // A run stopped past the slip window with no slip was a proper lock
            if (runCnt >= 5'h15 && !pllSlipIn) everLocked <= 1'b1;
            runCnt <= 5'h00;
            pllLockIn <= 1'b0;
            pllSlipIn <= 1'b0;
        end else begin
            if (runCnt != 5'h1F) runCnt <= runCnt + 5'h01;
            pllLockIn <= (runCnt >= 5'h02);
            // Slip comes late so the lock event is seen first; a clean lock ends the hazard
            pllSlipIn <= injectSlip && !everLocked && (runCnt >= 5'h14);
        end
    end
endmodule
`default_nettype wire

// ---- sim/test_pll_startup_lock_qualifier.sv ----
// Self-checking bench for the PLL start-up lock qualifier
`default_nettype none
module test_pll_startup_lock_qualifier;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BASE = 4;
    localparam int UNIT = 8;
    localparam logic [7:0] CTRL = pll_qual_pkg::OFF_CTRL;
    localparam logic [7:0] STAT = pll_qual_pkg::OFF_STATUS;
    localparam logic [7:0] SEL = pll_qual_pkg::OFF_SELECT;
    localparam logic [7:0] INTS = pll_qual_pkg::OFF_INT_STATUS;
    localparam logic [7:0] MASK = pll_qual_pkg::OFF_INT_MASK;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wrData = 32'h00000000;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic [31:0] rdData;
    logic pllLockIn;
    logic pllSlipIn;
    logic clockSourceDisable;
    logic mainClockSourceSelect;
    logic irq;
    logic [5:0] pllInputDivider;
    logic injectSlip = 1'b0;
    logic rdSeen = 1'b0;
    logic [31:0] expQ[$];
    logic [5:0] div;
    int n_mismatch = 0;
    int checks = 0;
    int seed = 30;
    int waitCnt;

    always #20 sys_clk = ~sys_clk;

    pll_startup_lock_qualifier #(.LOCK_BASE(BASE), .LOCK_UNIT(UNIT)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
        .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .pllLockIn(pllLockIn),
        .pllSlipIn(pllSlipIn), .clockSourceDisable(clockSourceDisable), .pllInputDivider(pllInputDivider),
        .mainClockSourceSelect(mainClockSourceSelect), .irq(irq));
    pll_analog_model pll_u (.sys_clk(sys_clk), .clockSourceDisable(clockSourceDisable),
        .injectSlip(injectSlip), .pllLockIn(pllLockIn), .pllSlipIn(pllSlipIn));

    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge sys_clk);
        wrEn <= 1'b0;
    endtask
    // Expected read data is queued here and compared by the monitor below
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        addr <= a;
        rdEn <= 1'b1;
        expQ.push_back(e);
        @(posedge sys_clk);
        rdEn <= 1'b0;
    endtask
    function automatic logic [31:0] ctrlWord(input logic dis, input logic [5:0] d, input logic q);
        ctrlWord = 32'h00000000;
        ctrlWord[pll_qual_pkg::CTRL_DISABLE_BIT] = dis;
        ctrlWord[pll_qual_pkg::CTRL_DIV_LSB +: 6] = d;
        ctrlWord[pll_qual_pkg::CTRL_QUAL_BIT] = q;
    endfunction
    // Enable the PLL and count cycles until the lock event raises irq
    task automatic lockAndTime(input logic [5:0] d);
        wr(CTRL, ctrlWord(1'b0, d, 1'b0));
        waitCnt = 0;
        while (irq !== 1'b1 && waitCnt < 300) begin
            @(posedge sys_clk);
            #1 waitCnt++;
        end
        if (waitCnt >= 300) begin
            n_mismatch++;
            final_report();
        end
        check("lockTime", 32'h1, 32'(waitCnt >= BASE + UNIT * d - 1 && waitCnt <= BASE + UNIT * d + 4));
    endtask

    always @(posedge sys_clk) begin
        if (rdSeen) check("rdData", expQ.pop_front(), rdData);
        rdSeen = rdEn;
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(CTRL, ctrlWord(1'b1, 6'h01, 1'b0));
        rd(STAT, 32'h00000004);
        rd(SEL, 32'h00000000);
        rd(MASK, 32'h00000000);
        rd(8'h14, 32'h00000000);
        wr(SEL, 32'h00000001);
        rd(SEL, 32'h00000000);
        check("irqMasked", 32'h0, {31'h0, irq});
        rd(INTS, 32'h00000004);
        rd(INTS, 32'h00000000);
        wr(MASK, 32'h00000007);
        // First start fails with a slip; polling looks at valid and slip together
        injectSlip <= 1'b1;
        lockAndTime(6'h01);
        repeat (16) @(posedge sys_clk);
        rd(STAT, 32'h00000007);
        wr(CTRL, ctrlWord(1'b0, 6'h01, 1'b1));
        wr(SEL, 32'h00000001);
        rd(SEL, 32'h00000000);
        rd(INTS, 32'h00000007);
        #1 check("irqClear", 32'h0, {31'h0, irq});
        // Retry with a random divider after disabling
        wr(CTRL, ctrlWord(1'b1, 6'h01, 1'b0));
        injectSlip <= 1'b0;
        div = 6'h01 + 6'($random(seed) & 3);
        lockAndTime(div);
        rd(STAT, 32'h00000005);
        wr(CTRL, ctrlWord(1'b0, div, 1'b1));
        wr(SEL, 32'h00000001);
        rd(SEL, 32'h00000001);
        check("select", 32'h1, {31'h0, mainClockSourceSelect});
        rd(STAT, 32'h00000001);
        rd(INTS, 32'h00000001);
        // Disable drops the selection; a restart after a clean lock stays clean
        wr(CTRL, ctrlWord(1'b1, div, 1'b0));
        rd(SEL, 32'h00000000);
        injectSlip <= 1'b1;
        lockAndTime(div);
        repeat (24) @(posedge sys_clk);
        rd(STAT, 32'h00000001);
        repeat (4) @(posedge sys_clk);
        final_report();
    end
endmodule
`default_nettype wire
